// ---- include/rros_pkg.sv ----
// constants and types shared by the one-shot driver files
// assumes a single 125 MHz clock domain and two external one-shot channels
package rros_pkg;

  // clock period in ns
  localparam int CLK_PERIOD_NS = 8;

  // least low time on the clear line, ns and cycles (rounded up)
  localparam int CLR_LOW_NS = 25;
  localparam int CLR_LOW_CYC = (CLR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // trigger level hold (release time), plain default, ns and cycles
  localparam int TRIG_HOLD_NS = 40;
  localparam int TRIG_HOLD_CYC = (TRIG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // gap between triggers (setup time), plain default, ns and cycles
  localparam int TRIG_SETUP_NS = 40;
  localparam int TRIG_SETUP_CYC = (TRIG_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // shortest true-output pulse the device may give, ns and cycles
  localparam int MIN_PULSE_NS = 65;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter widths
  localparam int CNT_W = 8;
  localparam int PULSE_W = 16;

  // number of channels in the device
  localparam int NUM_CH = 2;

  // idle levels of the driven pins after reset
  localparam logic RISE_IDLE = 1'h0;
  localparam logic FALL_IDLE = 1'h1;
  localparam logic CLR_IDLE = 1'h1;

  // per-channel driver states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRE,
    ST_SETUP,
    ST_CLEAR
  } rros_state_e;

endpackage : rros_pkg

// ---- logic/rros_driver.sv ----
// controller that drives a dual retriggerable resettable one-shot by its pins
// assumes device outputs arrive asynchronously and trigger commands are on clk
//
// How it works
// - non-retriggerable mode ignores triggers during pulse
// - clear driven low at least 25 ns
// - keep setup gap between successive triggers
// - hold each trigger level for release time, unless a clear request cuts it short
`timescale 1ns/10ps
`default_nettype none
module rros_driver
#(
  parameter int CH = rros_pkg::NUM_CH,
  parameter int CLR_CYC = rros_pkg::CLR_LOW_CYC,
  parameter int HOLD_CYC = rros_pkg::TRIG_HOLD_CYC,
  parameter int SETUP_CYC = rros_pkg::TRIG_SETUP_CYC,
  parameter int MINP_CYC = rros_pkg::MIN_PULSE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [CH-1:0] trig_req,
  input wire logic [CH-1:0] trig_rising,
  input wire logic [CH-1:0] non_retrig,
  input wire logic [CH-1:0] clear_req,
  input wire logic [CH-1:0] clear_hold,
  input wire logic [CH-1:0] pulse_q,
  input wire logic [CH-1:0] pulse_q_n,
  output logic [CH-1:0] rising_trigger_in,
  output logic [CH-1:0] falling_trigger_in,
  output logic [CH-1:0] direct_clear_n,
  output logic [CH-1:0] trig_busy,
  output logic [CH-1:0] trig_sent,
  output logic [CH-1:0] pulse_active,
  output logic [CH-1:0] pulse_end,
  output logic [CH-1:0] short_pulse,
  output logic [CH-1:0] complement_fault,
  output logic [CH*rros_pkg::PULSE_W-1:0] pulse_len
);

  import rros_pkg::*;

  // synchronised device outputs, true then complementary
  logic [2*CH-1:0] dev_sync;
  // idle pattern: true low, complementary high
  localparam logic [2*CH-1:0] DEV_IDLE = {{CH{1'h1}}, {CH{1'h0}}};

  // device outputs are foreign to clk, pass two flops first
  rros_sync #(
    .W(2 * CH),
    .RST_VAL(DEV_IDLE)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({pulse_q_n, pulse_q}),
    .q(dev_sync)
  );

  // counter load values, cut to counter width once
  localparam logic [CNT_W-1:0] CLR_LOAD = CNT_W'(CLR_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYC - 1);
  localparam logic [PULSE_W-1:0] MINP_LEN = PULSE_W'(MINP_CYC);
  localparam logic [PULSE_W-1:0] LEN_MAX = '1;

  // one identical, independent driver per channel
  genvar i;
  generate
    for (i = 0; i < CH; i++)
    begin : g_ch
      // state, down counter, latched edge choice
      rros_state_e state;
      rros_state_e next_state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] next_cnt;
      logic edge_up;
      // driven pin levels
      logic rise_lvl;
      logic fall_lvl;
      logic clr_lvl;
      // measurement of the returned pulse
      logic q_prev;
      logic [PULSE_W-1:0] meas;
      logic [PULSE_W-1:0] len;
      logic end_p;
      logic short_f;
      logic fault_f;
      logic sent_p;
      logic busy_f; // busy kept in a flop so the port has no decode behind it

      // decoded conditions
      wire q_s = dev_sync[i];
      wire qn_s = dev_sync[CH + i];
      wire cnt_zero = (cnt == '0);
      // an unwanted trigger while the pulse runs is dropped here
      wire retrig_block = non_retrig[i] & q_s;
      wire start_ok = trig_req[i] & ~retrig_block & ~clear_req[i];
      wire q_rise = q_s & ~q_prev;
      wire q_fall = ~q_s & q_prev;
      wire fire_next = (next_state == ST_FIRE);
      wire start_now = (state == ST_IDLE) & fire_next;
      // rising line goes high only while falling line is held high
      wire next_rise = fire_next & ((state == ST_FIRE) ? edge_up : trig_rising[i]);
      // falling line drops only while rising line stays low
      wire next_fall = ~(fire_next & ~((state == ST_FIRE) ? edge_up : trig_rising[i]));
      wire next_clr = (next_state != ST_CLEAR);
      wire mismatch = (q_s == qn_s);

      // next state: clear has priority over any trigger
      always_comb
      begin
        next_state = state;
        next_cnt = cnt;
        case (state)
          ST_IDLE:
          begin
            if (clear_req[i])
            begin
              next_state = ST_CLEAR;
              next_cnt = CLR_LOAD;
            end
            else if (start_ok)
            begin
              next_state = ST_FIRE;
              next_cnt = HOLD_LOAD;
            end
          end
          ST_FIRE:
          begin
            if (clear_req[i])
            begin
              next_state = ST_CLEAR;
              next_cnt = CLR_LOAD;
            end
            else if (cnt_zero)
            begin
              // level held long enough for the latch to cycle
              next_state = ST_SETUP;
              next_cnt = SETUP_LOAD;
            end
            else
            begin
              next_cnt = cnt - 1'h1;
            end
          end
          ST_SETUP:
          begin
            if (clear_req[i])
            begin
              next_state = ST_CLEAR;
              next_cnt = CLR_LOAD;
            end
            else if (cnt_zero)
            begin
              next_state = ST_IDLE;
            end
            else
            begin
              next_cnt = cnt - 1'h1;
            end
          end
          ST_CLEAR:
          begin
            // low time counted out, and held as long as asked
            if (cnt_zero & ~clear_hold[i] & ~clear_req[i])
            begin
              next_state = ST_IDLE;
            end
            else if (clear_req[i])
            begin
              next_cnt = CLR_LOAD;
            end
            else if (!cnt_zero)
            begin
              next_cnt = cnt - 1'h1;
            end
          end
          default:
          begin
            next_state = ST_IDLE;
            next_cnt = '0;
          end
        endcase
      end

      // state, counter and edge choice
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          state <= ST_IDLE;
          cnt <= '0;
          edge_up <= 1'h0;
        end
        else
        begin
          state <= next_state;
          cnt <= next_cnt;
          if (start_now)
          begin
            edge_up <= trig_rising[i];
          end
        end
      end

      // pin levels, registered so the pins never glitch
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          rise_lvl <= RISE_IDLE;
          fall_lvl <= FALL_IDLE;
          clr_lvl <= CLR_IDLE;
          sent_p <= 1'h0;
          busy_f <= 1'h0;
        end
        else
        begin
          rise_lvl <= next_rise;
          fall_lvl <= next_fall;
          clr_lvl <= next_clr;
          sent_p <= start_now;
          busy_f <= (next_state != ST_IDLE);
        end
      end

      // measure the returned pulse in clk cycles, saturating
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          q_prev <= 1'h0;
          meas <= '0;
          len <= '0;
          end_p <= 1'h0;
          short_f <= 1'h0;
        end
        else
        begin
          q_prev <= q_s;
          end_p <= q_fall;
          if (q_rise)
          begin
            meas <= PULSE_W'(1);
          end
          else if (q_s && meas != LEN_MAX)
          begin
            meas <= meas + 1'h1;
          end
          // retriggers show up as a longer pulse, not a new one
          if (q_fall)
          begin
            len <= meas;
            short_f <= (meas < MINP_LEN);
          end
        end
      end

      // sticky complement fault; a new mismatch beats the clear
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          fault_f <= 1'h0;
        end
        else
        begin
          fault_f <= mismatch | (fault_f & ~clear_req[i]);
        end
      end

      // hand channel flops out to the port vectors
      assign rising_trigger_in[i] = rise_lvl;
      assign falling_trigger_in[i] = fall_lvl;
      assign direct_clear_n[i] = clr_lvl;
      assign trig_busy[i] = busy_f;
      assign trig_sent[i] = sent_p;
      assign pulse_active[i] = q_prev;
      assign pulse_end[i] = end_p;
      assign short_pulse[i] = short_f;
      assign complement_fault[i] = fault_f;
      assign pulse_len[i*PULSE_W +: PULSE_W] = len;
    end
  endgenerate

endmodule : rros_driver
`default_nettype wire

// ---- logic/rros_sync.sv ----
// two-flop synchroniser for a vector of pin inputs
// assumes each bit is an independent slow level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module rros_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // first stage, read only by the second stage
  logic [W-1:0] meta;

  // plain double register, reset to the pin idle pattern
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : rros_sync
`default_nettype wire

// ---- verif/rros_dev_model.sv ----
// behavioural model of the dual one-shot device, time counted in clk cycles
// assumes pins change just after clk edges, pulse lengths given as parameters
`timescale 1ns/10ps
`default_nettype none
module rros_dev_model #(
  parameter int PW0 = 20,
  parameter int PW1 = 30
) (
  input wire logic clk,
  input wire logic [1:0] rise_in,
  input wire logic [1:0] fall_in,
  input wire logic [1:0] clr_n,
  input wire logic fault,
  output logic [1:0] q,
  output logic [1:0] q_n
);
  bit [1:0] rise_p; // last trigger levels
  bit [1:0] fall_p;
  int cnt [2]; // cycles left in the pulse
  // channels share nothing but the clock
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      rise_p[i] <= rise_in[i];
      fall_p[i] <= fall_in[i];
      // clear low beats any edge seen at the same time
      if (!clr_n[i])
        cnt[i] <= 0;
      else if ((rise_in[i] && !rise_p[i] && fall_in[i]) ||
               (!fall_in[i] && fall_p[i] && !rise_in[i]))
        cnt[i] <= (i == 0) ? PW0 : PW1;
      else if (cnt[i] > 0)
        cnt[i] <= cnt[i] - 1;
    end
  end
  // reload keeps q high, so a retrigger has no glitch
  assign q = {cnt[1] > 0, cnt[0] > 0};
  // fault breaks the complement on channel 0 only
  assign q_n = ~q ^ {1'h0, fault};
endmodule : rros_dev_model
`default_nettype wire

// ---- verif/rros_drv_monitor.sv ----
// checker bound to the one-shot driver ports
// assumes one clk domain; clear checks on channel 0, trigger timing on 1
`timescale 1ns/10ps
`default_nettype none
module rros_drv_monitor #(
  parameter int CH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [CH-1:0] trig_req,
  input wire logic [CH-1:0] trig_rising,
  input wire logic [CH-1:0] non_retrig,
  input wire logic [CH-1:0] clear_req,
  input wire logic [CH-1:0] rising_trigger_in,
  input wire logic [CH-1:0] falling_trigger_in,
  input wire logic [CH-1:0] direct_clear_n,
  input wire logic [CH-1:0] trig_busy,
  input wire logic [CH-1:0] trig_sent,
  input wire logic [CH-1:0] pulse_active,
  input wire logic [CH-1:0] complement_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  clr_len_a: assert property ($fell(direct_clear_n[0]) |-> !direct_clear_n[0] [*4])
    else $error("clear low too short");
  clr_idle_a: assert property (!direct_clear_n[0] |-> !rising_trigger_in[0] && falling_trigger_in[0])
    else $error("trigger level during clear");
  clr_take_a: assert property (clear_req[0] |=> !direct_clear_n[0])
    else $error("clear not driven");
  clr_cause_a: assert property ($fell(direct_clear_n[0]) |-> $past(clear_req[0]))
    else $error("clear without request");
  take_rise_a: assert property (trig_req[0] && !clear_req[0] && !trig_busy[0] && !non_retrig[0]
    && trig_rising[0] |=> trig_sent[0] && rising_trigger_in[0])
    else $error("rising trigger not sent");
  sent_lvl_a: assert property (trig_sent[1] |-> (rising_trigger_in[1] || !falling_trigger_in[1])
    ##1 !trig_sent[1])
    else $error("sent without trigger level");
  hold_rise_a: assert property ($rose(rising_trigger_in[1]) |-> rising_trigger_in[1] [*5]
    ##1 !rising_trigger_in[1])
    else $error("rising level hold wrong");
  hold_fall_a: assert property ($fell(falling_trigger_in[1]) |-> !falling_trigger_in[1] [*5]
    ##1 falling_trigger_in[1])
    else $error("falling level hold wrong");
  trig_gap_a: assert property ($fell(rising_trigger_in[1]) |->
    (!rising_trigger_in[1] && falling_trigger_in[1]) [*5])
    else $error("setup gap too short");
  nr_block_a: assert property ((non_retrig[0] && trig_req[0]) ##1 pulse_active[0]
    |-> !trig_sent[0])
    else $error("trigger sent during pulse");
  fault_keep_a: assert property (complement_fault[0] && !clear_req[0] |=> complement_fault[0])
    else $error("fault flag lost");
endmodule : rros_drv_monitor
bind rros_driver rros_drv_monitor #(.CH(CH)) u_mon (.clk, .sys_rst, .trig_req, .trig_rising,
  .non_retrig, .clear_req, .rising_trigger_in, .falling_trigger_in, .direct_clear_n,
  .trig_busy, .trig_sent, .pulse_active, .complement_fault);
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench: driver against the one-shot device model
// assumes rros_pkg, driver, model and monitor are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  import rros_pkg::*;
  localparam int PW0 = 20; // model pulse lengths, cycles
  localparam int PW1 = 30;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [1:0] trig_req = 2'h0, trig_rising = 2'h0, non_retrig = 2'h0;
  logic [1:0] clear_req = 2'h0, clear_hold = 2'h0;
  logic fault = 1'h0;
  wire logic [1:0] pq, pqn, rise_pin, fall_pin, clr_pin, busy, sent, active, p_end, short_p, cfault;
  wire logic [31:0] plen;
  int failures = 0;
  int num_checks = 0;
  int c, s, k;
  rros_driver dut (.clk(clk), .sys_rst(sys_rst), .trig_req(trig_req), .trig_rising(trig_rising),
    .non_retrig(non_retrig), .clear_req(clear_req), .clear_hold(clear_hold), .pulse_q(pq),
    .pulse_q_n(pqn), .rising_trigger_in(rise_pin), .falling_trigger_in(fall_pin),
    .direct_clear_n(clr_pin), .trig_busy(busy), .trig_sent(sent), .pulse_active(active),
    .pulse_end(p_end), .short_pulse(short_p), .complement_fault(cfault), .pulse_len(plen));
  rros_dev_model #(.PW0(PW0), .PW1(PW1)) u_dev (.clk(clk), .rise_in(rise_pin), .fall_in(fall_pin),
    .clr_n(clr_pin), .fault(fault), .q(pq), .q_n(pqn));
  // free-running 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end
  // length of a pulse retriggered n times at the shortest spacing
  function automatic int exp_len(int ch, int n);
    return (ch == 1 ? PW1 : PW0) + n * (TRIG_HOLD_CYC + TRIG_SETUP_CYC + 1);
  endfunction : exp_len
  // one request, lowered at the edge that takes it
  task automatic fire(int ch, logic r);
    @(posedge clk);
    trig_rising[ch] <= r;
    trig_req[ch] <= 1'h1;
    @(posedge clk);
    trig_req[ch] <= 1'h0;
  endtask : fire
  // bounded wait for the end marker, then check the measurement
  task automatic wait_end(int ch, int len);
    k = 0;
    @(posedge clk);
    while (p_end[ch] !== 1'h1 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    `CHK("pulse_end", 1'h1, p_end[ch])
    `CHK("pulse_len", 16'(len), plen[ch*16+:16])
    `CHK("short_pulse", len < MIN_PULSE_CYC, short_p[ch])
  endtask : wait_end
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // hang guard at 12500 cycles, far beyond the few hundred cycles needed
  initial
  begin
    #100000;
    failures++;
    final_report();
  end
  // main sequence
  initial
  begin
    void'($urandom(48814));
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    // random single pulses, either channel, either edge
    for (int i = 0; i < 12; i++)
    begin
      c = $urandom % 2;
      repeat ($urandom % 8) @(posedge clk);
      fire(c, 1'($urandom));
      wait_end(c, exp_len(c, 0));
    end
    // request held high: retriggers at the shortest spacing
    @(posedge clk);
    trig_rising[0] <= 1'h1;
    trig_req[0] <= 1'h1;
    repeat (23) @(posedge clk);
    trig_req[0] <= 1'h0;
    wait_end(0, exp_len(0, 2));
    `CHK("complement_fault", 1'h0, cfault[0])
    // held request in non-retrigger mode: only the first goes out
    non_retrig[0] <= 1'h1;
    trig_rising[0] <= 1'h0;
    trig_req[0] <= 1'h1;
    s = 0;
    repeat (16) begin @(posedge clk); s += int'(sent[0]); end
    trig_req[0] <= 1'h0;
    non_retrig[0] <= 1'h0;
    `CHK("sent_count", 1, s)
    wait_end(0, exp_len(0, 0));
    // clear cuts a pulse short, then blocks a held request
    fire(0, 1'h1);
    @(posedge clk);
    clear_req[0] <= 1'h1;
    clear_hold[0] <= 1'h1;
    trig_req[0] <= 1'h1;
    s = 0;
    repeat (12) begin @(posedge clk); s += int'(sent[0]); end
    `CHK("sent_in_clear", 0, s)
    `CHK("short_pulse", 1'h1, short_p[0])
    clear_req[0] <= 1'h0;
    clear_hold[0] <= 1'h0;
    for (k = 0; k < 20 && sent[0] !== 1'h1; k++) @(posedge clk);
    trig_req[0] <= 1'h0;
    wait_end(0, exp_len(0, 0));
    // broken complement sets the sticky flag, clear removes it
    fault <= 1'h1;
    repeat (6) @(posedge clk);
    fault <= 1'h0;
    repeat (4) @(posedge clk);
    `CHK("complement_fault", 1'h1, cfault[0])
    clear_req[0] <= 1'h1;
    @(posedge clk);
    clear_req[0] <= 1'h0;
    repeat (8) @(posedge clk);
    `CHK("complement_fault", 1'h0, cfault[0])
    final_report();
  end
endmodule : tb_top
`default_nettype wire
